/* File: pmc_cfg.svh */
// Constants of the closed-loop motor control datapath.
// Assumes a 50 MHz clock; included by bare name.
// Overview of operation
// - Serial mode: raw input equals target.
// - Analog input: receive pin conversion, 4092 = 5V.
// - Pulse input: last pulse width in 2/3 us.
// - Non-serial modes scale raw input to target.
// - Analog feedback: sense pin conversion, 4092 = 5V.
// - No feedback mode holds raw feedback zero.
// - Scaled feedback from raw by own scaling.
// - Current is 8-bit sense conversion, 255 = 5V.
// - Current reads zero unless limit enabled.
// - Each period add feedback minus target to sum.
// - Clear sum when idle or proportional over max.
// - Clamp error sum magnitude to integral limit.
// - Signed duty: +-600 full, zero brakes.
// - Speed mode: duty target is target minus 2048.
// - Feedback modes: duty target is P+I+D.
// - Applied duty honours max and current; accel and brake hold apply unless the duty target bound cuts duty.
// - Applied duty magnitude never exceeds duty target.
// - 16-bit wrapping period counter, configurable period.
// - Unlisted 0x81..0xBF bytes read, reply, no error.
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

`define PMC_CLK_NS        20
`define PMC_TICK_NUM_NS   2000
`define PMC_TICK_DEN      3
`define PMC_TICK_CYCLES   (`PMC_TICK_NUM_NS / (`PMC_TICK_DEN * `PMC_CLK_NS))
`define PMC_MS_NS         1000000
`define PMC_MS_CYCLES     (`PMC_MS_NS / `PMC_CLK_NS)
`define PMC_RAW_MAX       34'sh0_0000_0fff
`define PMC_DUTY_FULL     16'sh0258
`define PMC_SPEED_OFFSET  17'sh00800
`define PMC_SCALE_SHIFT   8
`define PMC_COEF_SHIFT    4
`define PMC_CMD_READ_LO   8'h81
`define PMC_CMD_READ_HI   8'hbf
`define PMC_VAR_COUNT     4'h9
`define PMC_VAR_INPUT     4'h0
`define PMC_VAR_TARGET    4'h1
`define PMC_VAR_FEEDBACK  4'h2
`define PMC_VAR_SCALED    4'h3
`define PMC_VAR_ERRSUM    4'h4
`define PMC_VAR_DUTY_TGT  4'h5
`define PMC_VAR_DUTY      4'h6
`define PMC_VAR_CURRENT   4'h7
`define PMC_VAR_PIDCOUNT  4'h8

`endif

/* File: pmc_pkg.sv */
// Types shared by the motor control datapath modules.
// Assumes pmc_cfg.svh for numeric constants.
package pmc_pkg;
	typedef enum logic [1:0] {in_serial, in_analog, in_pulse} pmc_in_mode_t;
	typedef enum logic {fb_none, fb_analog} pmc_fb_mode_t;
	typedef enum logic [1:0] {rp_idle, rp_addr, rp_load} pmc_reply_state_t;
endpackage : pmc_pkg

/* File: pmc_var_if.sv */
// Write and read port of the variable snapshot memory.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface pmc_var_if #(parameter int AW = 4, parameter int DW = 16);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport writer (output we, output waddr, output wdata, output raddr, input rdata);
	modport store  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : pmc_var_if

/* File: pmc_var_mem.sv */
// Snapshot memory of the readable variables, registered read data.
// Assumes a synchronous writer on the same clock.
`timescale 1ns/1ns
module pmc_var_mem #(
	parameter int AW = 4,
	parameter int DW = 16
) (
	// Clock
	input wire logic  clock,
	// Ports
	pmc_var_if.store  mem
);
	logic [DW-1:0] store_q [2**AW];
	logic [DW-1:0] rdata_q;

	initial
	begin
		if (AW < 4 || DW < 16)
			$error("pmc_var_mem: needs at least 16 words of 16 bits");
	end

	always_ff @(posedge clock)
	begin
		if (mem.we)
			store_q[mem.waddr] <= mem.wdata;
		rdata_q <= store_q[mem.raddr];
	end

	assign mem.rdata = rdata_q;
endmodule : pmc_var_mem

/* File: pmc_pulse_meter.sv */
// Measures high pulse width in ticks of a prescaled clock.
// Assumes the pulse input is synchronous to clock.
`timescale 1ns/1ns
module pmc_pulse_meter #(
	parameter int TICK_CYCLES = 33,
	parameter int WIDTH       = 16
) (
	// Clock and reset
	input wire logic             clock,
	input wire logic             rst,
	// Pulse in
	input wire logic             pulse,
	// Last width
	output logic [WIDTH-1:0]     width
);
	logic [7:0]       pre;
	logic [WIDTH-1:0] cnt;
	logic             pulse_d;
	logic [7:0]       next_pre;
	logic [WIDTH-1:0] next_cnt;
	logic [WIDTH-1:0] next_width;

	initial
	begin
		if (TICK_CYCLES < 1 || TICK_CYCLES > 255)
			$error("pmc_pulse_meter: tick length out of range");
	end

	always_comb
	begin
		next_pre   = pre;
		next_cnt   = cnt;
		next_width = width;
		if (pulse)
		begin
			if (pre == 8'(TICK_CYCLES - 1))
			begin
				next_pre = 8'h00;
				if (cnt != '1)
					next_cnt = cnt + 1'b1;
			end
			else
				next_pre = pre + 8'h01;
		end
		else
		begin
			next_pre = 8'h00;
			next_cnt = '0;
			if (pulse_d)
				next_width = cnt;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pre     <= 8'h00;
			cnt     <= '0;
			width   <= '0;
			pulse_d <= 1'b0;
		end
		else
		begin
			pre     <= next_pre;
			cnt     <= next_cnt;
			width   <= next_width;
			pulse_d <= pulse;
		end
	end
endmodule : pmc_pulse_meter

/* File: pmc_motor_ctrl.sv */
// Closed-loop motor control datapath: input, feedback, PID, duty, readback.
// Assumes converter samples and host bytes are synchronous to clock.
`timescale 1ns/1ns
`include "pmc_cfg.svh"
module pmc_motor_ctrl
	import pmc_pkg::*;
#(
	parameter int MS_CYCLES = `PMC_MS_CYCLES
) (
	// Clock and reset
	input wire logic               clock,
	input wire logic               rst,
	// Modes and enables
	input wire logic [1:0]         input_mode,
	input wire logic               feedback_mode,
	input wire logic               motor_enable,
	input wire logic               current_limit_en,
	input wire logic               reset_integral_opt,
	// Sensor samples
	input wire logic [11:0]        rx_level,
	input wire logic               rx_pulse,
	input wire logic [11:0]        feedback_sense_pin_level,
	input wire logic [7:0]         current_sense_level,
	// Scaling
	input wire logic [15:0]        in_gain,
	input wire logic signed [15:0] in_offset,
	input wire logic [15:0]        fb_gain,
	input wire logic signed [15:0] fb_offset,
	// PID and limits
	input wire logic [15:0]        kp,
	input wire logic [15:0]        ki,
	input wire logic [15:0]        kd,
	input wire logic [14:0]        integral_limit,
	input wire logic [7:0]         pid_period_ms,
	input wire logic [9:0]         max_duty,
	input wire logic [9:0]         max_accel,
	input wire logic [7:0]         max_current,
	input wire logic [7:0]         brake_periods,
	// Serial host
	input wire logic               set_target_valid,
	input wire logic [11:0]        set_target_value,
	input wire logic               cmd_valid,
	input wire logic [7:0]         cmd_byte,
	// Variables
	output logic [15:0]            raw_input,
	output logic [11:0]            target,
	output logic [11:0]            raw_feedback,
	output logic [11:0]            scaled_feedback,
	output logic [7:0]             current_reading,
	output logic signed [15:0]     error_sum,
	output logic signed [15:0]     duty_target,
	output logic signed [15:0]     duty_cycle,
	output logic [15:0]            pid_count,
	// Replies
	output logic                   cmd_busy,
	output logic                   reply_valid,
	output logic                   reply_two,
	output logic [15:0]            reply_data
);
	pmc_var_if #(.AW(4), .DW(16)) vars ();
	pmc_reply_state_t state, next_state;
	logic [15:0] pulse_width;
	logic [31:0] ms_cnt, next_ms_cnt;
	logic [7:0]  per_cnt, next_per_cnt;
	logic        pid_tick, next_pid_tick;
	logic signed [16:0] last_err, next_last_err;
	logic [7:0]  brake_left, next_brake_left;
	logic [3:0]  scan, next_scan;
	logic [3:0]  rd_idx, next_rd_idx;
	logic [1:0]  rd_kind, next_rd_kind;
	logic [15:0] wsel;
	logic [15:0] next_raw_input;
	logic [11:0] next_target, next_raw_fb, next_scaled;
	logic [7:0]  next_current;
	logic signed [15:0] next_error_sum, next_duty_target, next_duty;
	logic [15:0] next_pid_count;
	logic        next_reply_valid, next_reply_two;
	logic [15:0] next_reply_data;
	logic signed [16:0] err;
	logic signed [35:0] p_term, i_term, d_term, pid_sum;
	logic signed [17:0] acc;
	logic signed [16:0] goal, step, lim, lo, hi;
	logic [7:0]  off;

	initial
	begin
		if (MS_CYCLES < 1)
			$error("pmc_motor_ctrl: MS_CYCLES must be positive");
	end

	function automatic logic [11:0] pmc_scale(input logic [15:0] raw,
		input logic [15:0] gain, input logic signed [15:0] offset);
		logic signed [33:0] s;
		s = $signed({2'b00, 32'(raw) * 32'(gain)});
		s = (s >>> `PMC_SCALE_SHIFT) + 34'(offset);
		if (s < 0)
			return 12'h000;
		else if (s > `PMC_RAW_MAX)
			return 12'hfff;
		return s[11:0];
	endfunction : pmc_scale

	pmc_pulse_meter #(.TICK_CYCLES(`PMC_TICK_CYCLES), .WIDTH(16)) u_meter (
		.clock (clock),
		.rst   (rst),
		.pulse (rx_pulse),
		.width (pulse_width)
	);

	pmc_var_mem #(.AW(4), .DW(16)) u_mem (
		.clock (clock),
		.mem   (vars.store)
	);

	// Sensing and scaling, refreshed every clock
	always_comb
	begin
		next_target = target;
		case (pmc_in_mode_t'(input_mode))
			in_serial:
			begin
				if (set_target_valid)
					next_target = set_target_value;
				next_raw_input = {4'h0, target};
			end
			in_analog: next_raw_input = {4'h0, rx_level};
			in_pulse:  next_raw_input = pulse_width;
			default:   next_raw_input = 16'h0000;
		endcase
		if (pmc_in_mode_t'(input_mode) != in_serial)
			next_target = pmc_scale(raw_input, in_gain, in_offset);
		if (pmc_fb_mode_t'(feedback_mode) == fb_analog)
			next_raw_fb = feedback_sense_pin_level;
		else
			next_raw_fb = 12'h000;
		next_scaled = pmc_scale({4'h0, raw_feedback}, fb_gain, fb_offset);
		next_current = current_limit_en ? current_sense_level : 8'h00;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			raw_input       <= 16'h0000;
			target          <= 12'h000;
			raw_feedback    <= 12'h000;
			scaled_feedback <= 12'h000;
			current_reading <= 8'h00;
		end
		else
		begin
			raw_input       <= next_raw_input;
			target          <= next_target;
			raw_feedback    <= next_raw_fb;
			scaled_feedback <= next_scaled;
			current_reading <= next_current;
		end
	end

	// PID period timing
	always_comb
	begin
		next_ms_cnt    = ms_cnt + 32'h1;
		next_per_cnt   = per_cnt;
		next_pid_tick  = 1'b0;
		next_pid_count = pid_count;
		if (ms_cnt >= 32'(MS_CYCLES - 1))
		begin
			next_ms_cnt  = 32'h0;
			next_per_cnt = per_cnt + 8'h01;
			if (next_per_cnt >= pid_period_ms || pid_period_ms == 8'h00)
			begin
				next_per_cnt  = 8'h00;
				next_pid_tick = 1'b1;
			end
		end
		if (pid_tick)
			next_pid_count = pid_count + 16'h0001;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ms_cnt    <= 32'h0;
			per_cnt   <= 8'h00;
			pid_tick  <= 1'b0;
			pid_count <= 16'h0000;
		end
		else
		begin
			ms_cnt    <= next_ms_cnt;
			per_cnt   <= next_per_cnt;
			pid_tick  <= next_pid_tick;
			pid_count <= next_pid_count;
		end
	end

	// Control computation, committed only on the period tick
	always_comb
	begin
		err = 17'(signed'({5'h00, scaled_feedback})) - 17'(signed'({5'h00, target}));
		p_term = (36'(signed'({1'b0, kp})) * 36'(err)) >>> `PMC_COEF_SHIFT;
		i_term = (36'(signed'({1'b0, ki})) * 36'(error_sum)) >>> `PMC_COEF_SHIFT;
		d_term = (36'(signed'({1'b0, kd})) * 36'(err - last_err)) >>> `PMC_COEF_SHIFT;
		pid_sum = p_term + i_term + d_term;
		acc = 18'(error_sum) + 18'(err);
		lim = 17'(signed'({2'b00, integral_limit}));
		next_error_sum   = error_sum;
		next_duty_target = duty_target;
		next_last_err    = last_err;
		next_duty        = duty_cycle;
		next_brake_left  = brake_left;
		goal = 17'h0;
		step = 17'h0;
		lo   = 17'h0;
		hi   = 17'h0;
		if (pid_tick)
		begin
			next_last_err = err;
			if (!motor_enable)
				next_error_sum = 16'sh0000;
			else if (reset_integral_opt && (p_term > 36'(signed'({1'b0, max_duty}))
				|| -p_term > 36'(signed'({1'b0, max_duty}))))
				next_error_sum = 16'sh0000;
			else if (acc > 18'(lim))
				next_error_sum = lim[15:0];
			else if (acc < -18'(lim))
				next_error_sum = 16'(-lim);
			else
				next_error_sum = acc[15:0];
			if (pmc_fb_mode_t'(feedback_mode) == fb_none)
				next_duty_target = 16'(17'(signed'({5'h00, target})) - `PMC_SPEED_OFFSET);
			else if (pid_sum > 36'sd32767)
				next_duty_target = 16'sh7fff;
			else if (pid_sum < -36'sd32768)
				next_duty_target = 16'sh8000;
			else
				next_duty_target = pid_sum[15:0];
			// Goal: duty target within max duty and full scale, zero on overcurrent
			goal = 17'(next_duty_target);
			if (goal > 17'(`PMC_DUTY_FULL))
				goal = 17'(`PMC_DUTY_FULL);
			if (goal < -17'(`PMC_DUTY_FULL))
				goal = -17'(`PMC_DUTY_FULL);
			if (goal > 17'(signed'({7'h00, max_duty})))
				goal = 17'(signed'({7'h00, max_duty}));
			if (goal < -17'(signed'({7'h00, max_duty})))
				goal = -17'(signed'({7'h00, max_duty}));
			if (!motor_enable || (current_limit_en && current_reading > max_current))
				goal = 17'h0;
			step = goal - 17'(duty_cycle);
			if (max_accel != 10'h000 && step > 17'(signed'({7'h00, max_accel})))
				step = 17'(signed'({7'h00, max_accel}));
			if (max_accel != 10'h000 && step < -17'(signed'({7'h00, max_accel})))
				step = -17'(signed'({7'h00, max_accel}));
			goal = 17'(duty_cycle) + step;
			// Reversal passes through a brake hold of brake_periods
			if (brake_left != 8'h00)
			begin
				goal = 17'h0;
				next_brake_left = brake_left - 8'h01;
			end
			else if ((duty_cycle > 0 && goal < 0) || (duty_cycle < 0 && goal > 0))
			begin
				goal = 17'h0;
				next_brake_left = brake_periods;
			end
			lo = (next_duty_target < 0) ? 17'(next_duty_target) : 17'h0;
			hi = (next_duty_target > 0) ? 17'(next_duty_target) : 17'h0;
			if (goal < lo)
				goal = lo;
			if (goal > hi)
				goal = hi;
			next_duty = goal[15:0];
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			error_sum   <= 16'sh0000;
			duty_target <= 16'sh0000;
			duty_cycle  <= 16'sh0000;
			last_err    <= 17'sh00000;
			brake_left  <= 8'h00;
		end
		else
		begin
			error_sum   <= next_error_sum;
			duty_target <= next_duty_target;
			duty_cycle  <= next_duty;
			last_err    <= next_last_err;
			brake_left  <= next_brake_left;
		end
	end

	// Variable snapshot and read replies
	always_comb
	begin
		case (scan)
			`PMC_VAR_INPUT:    wsel = raw_input;
			`PMC_VAR_TARGET:   wsel = {4'h0, target};
			`PMC_VAR_FEEDBACK: wsel = {4'h0, raw_feedback};
			`PMC_VAR_SCALED:   wsel = {4'h0, scaled_feedback};
			`PMC_VAR_ERRSUM:   wsel = error_sum;
			`PMC_VAR_DUTY_TGT: wsel = duty_target;
			`PMC_VAR_DUTY:     wsel = duty_cycle;
			`PMC_VAR_CURRENT:  wsel = {8'h00, current_reading};
			default:           wsel = pid_count;
		endcase
		next_scan = (scan == `PMC_VAR_COUNT - 4'h1) ? 4'h0 : scan + 4'h1;
		off = cmd_byte - `PMC_CMD_READ_LO;
		next_state       = state;
		next_rd_idx      = rd_idx;
		next_rd_kind     = rd_kind;
		next_reply_valid = 1'b0;
		next_reply_two   = reply_two;
		next_reply_data  = reply_data;
		case (state)
			rp_idle:
				if (cmd_valid && cmd_byte >= `PMC_CMD_READ_LO && cmd_byte <= `PMC_CMD_READ_HI)
				begin
					next_rd_idx  = off[4:1];
					next_rd_kind = {off[5], off[0]};
					next_state   = rp_addr;
				end
			rp_addr:
				next_state = rp_load;
			default:
			begin
				next_state       = rp_idle;
				next_reply_valid = 1'b1;
				next_reply_two   = rd_kind[1];
				if (rd_idx >= `PMC_VAR_COUNT)
					next_reply_data = 16'h0000;
				else if (rd_kind[1])
					next_reply_data = vars.rdata;
				else if (rd_kind[0])
					next_reply_data = {8'h00, vars.rdata[15:8]};
				else
					next_reply_data = {8'h00, vars.rdata[7:0]};
			end
		endcase
	end

	assign vars.we    = 1'b1;
	assign vars.waddr = scan;
	assign vars.wdata = wsel;
	assign vars.raddr = rd_idx;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state       <= rp_idle;
			scan        <= 4'h0;
			rd_idx      <= 4'h0;
			rd_kind     <= 2'h0;
			cmd_busy    <= 1'b0;
			reply_valid <= 1'b0;
			reply_two   <= 1'b0;
			reply_data  <= 16'h0000;
		end
		else
		begin
			state       <= next_state;
			scan        <= next_scan;
			rd_idx      <= next_rd_idx;
			rd_kind     <= next_rd_kind;
			cmd_busy    <= (next_state != rp_idle);
			reply_valid <= next_reply_valid;
			reply_two   <= next_reply_two;
			reply_data  <= next_reply_data;
		end
	end
endmodule : pmc_motor_ctrl

/* File: pmc_far_model.sv */
// Far side of the datapath: pulse source and converter levels.
// Assumes the bench calls its tasks just after a clock edge.
`timescale 1ns/1ns
module pmc_far_model (
	// Clock
	input wire logic clock,
	// Sensor levels and pulse
	output logic        rx_pulse,
	output logic [11:0] feedback_sense_pin_level,
	output logic [7:0]  current_sense_level
);
	initial
	begin
		rx_pulse = 1'b0;
		feedback_sense_pin_level = 12'h000;
		current_sense_level = 8'h00;
	end
	// High pulse of n whole cycles, edges placed just after a clock edge
	task automatic send_pulse(input int n);
		@(posedge clock);
		#2 rx_pulse = 1'b1;
		repeat (n) @(posedge clock);
		#2 rx_pulse = 1'b0;
	endtask : send_pulse
	task automatic set_levels(input logic [11:0] fb, input logic [7:0] cur);
		feedback_sense_pin_level = fb;
		current_sense_level = cur;
	endtask : set_levels
endmodule : pmc_far_model

/* File: pmc_motor_ctrl_properties.sv */
// Port-level checks of the motor control datapath.
// Assumes binding to pmc_motor_ctrl; one clock, synchronous reset.
`timescale 1ns/1ns
module pmc_motor_ctrl_properties (
	// Clock and reset
	input wire logic               clock,
	input wire logic               rst,
	// Inputs watched
	input wire logic [1:0]         input_mode,
	input wire logic               feedback_mode,
	input wire logic               motor_enable,
	input wire logic               current_limit_en,
	input wire logic [11:0]        rx_level,
	input wire logic [11:0]        feedback_sense_pin_level,
	input wire logic [7:0]         current_sense_level,
	input wire logic [14:0]        integral_limit,
	input wire logic               cmd_valid,
	input wire logic [7:0]         cmd_byte,
	// Outputs watched
	input wire logic [15:0]        raw_input,
	input wire logic [11:0]        target,
	input wire logic [11:0]        raw_feedback,
	input wire logic [7:0]         current_reading,
	input wire logic signed [15:0] error_sum,
	input wire logic signed [15:0] duty_target,
	input wire logic signed [15:0] duty_cycle,
	input wire logic [15:0]        pid_count,
	input wire logic               cmd_busy,
	input wire logic               reply_valid
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	serial_input_a:
		assert property (input_mode == 2'h0 |=> raw_input == {4'h0, $past(target)})
		else $error("raw input not following target");
	analog_input_a:
		assert property (input_mode == 2'h1 |=> raw_input == {4'h0, $past(rx_level)})
		else $error("raw input not the receive level");
	fb_level_a:
		assert property (feedback_mode |=> raw_feedback == $past(feedback_sense_pin_level))
		else $error("raw feedback not the sense level");
	fb_zero_a:
		assert property (!feedback_mode |=> raw_feedback == 12'h000)
		else $error("raw feedback not zero");
	current_on_a:
		assert property (current_limit_en |=> current_reading == $past(current_sense_level))
		else $error("current reading wrong");
	current_off_a:
		assert property (!current_limit_en |=> current_reading == 8'h00)
		else $error("current reading not zero");
	idle_sum_a:
		assert property ($changed(pid_count) && !$past(rst) && !$past(motor_enable)
			|-> error_sum == 16'sh0000)
		else $error("error sum not cleared");
	sum_limit_a:
		assert property (error_sum <= $signed({1'b0, integral_limit})
			&& error_sum >= -$signed({1'b0, integral_limit}))
		else $error("error sum over limit");
	duty_range_a:
		assert property (duty_cycle <= 16'sh0258 && duty_cycle >= -16'sh0258)
		else $error("duty outside full scale");
	speed_duty_a:
		assert property ($changed(pid_count) && !$past(rst) && !$past(feedback_mode)
			|-> duty_target == $signed({4'h0, $past(target)}) - 16'sh0800)
		else $error("speed duty target wrong");
	duty_bound_a:
		assert property ((duty_cycle > 16'sh0000) ? (duty_target >= duty_cycle)
			: (duty_cycle == 16'sh0000 || duty_target <= duty_cycle))
		else $error("duty exceeds duty target");
	count_step_a:
		assert property ($changed(pid_count) && !$past(rst)
			|-> pid_count == $past(pid_count) + 16'h0001)
		else $error("period count step wrong");
	atomic_update_a:
		assert property (($changed(error_sum) || $changed(duty_target)) && !$past(rst)
			|-> $changed(pid_count))
		else $error("update outside period boundary");
	read_reply_a:
		assert property (cmd_valid && !cmd_busy && cmd_byte >= 8'h81 && cmd_byte <= 8'hbf
			|=> cmd_busy ##1 cmd_busy ##1 (reply_valid && !cmd_busy))
		else $error("read reply timing wrong");
endmodule : pmc_motor_ctrl_properties
bind pmc_motor_ctrl pmc_motor_ctrl_properties pmc_motor_ctrl_properties_inst (.*);

/* File: pmc_motor_ctrl_tb.sv */
// Self-checking bench of the motor control datapath.
// Assumes a PID period of 10 cycles through a short millisecond count.
`timescale 1ns/1ns
module pmc_motor_ctrl_tb;
	logic clock = 1'b0, rst = 1'b1;
	logic [1:0] input_mode = 2'h0;
	logic feedback_mode = 1'b0, motor_enable = 1'b0, current_limit_en = 1'b0;
	logic reset_integral_opt = 1'b0, set_target_valid = 1'b0, cmd_valid = 1'b0;
	logic [11:0] rx_level = 12'h000, set_target_value = 12'h000;
	logic [15:0] in_gain = 16'h0100, fb_gain = 16'h0100, kp = 16'h0010;
	logic [15:0] ki = 16'h0010, kd = 16'h0000;
	logic signed [15:0] in_offset = 16'sh0000, fb_offset = 16'sh0000;
	logic [14:0] integral_limit = 15'h0064;
	logic [7:0] pid_period_ms = 8'h01, max_current = 8'hff, brake_periods = 8'h02;
	logic [7:0] cmd_byte = 8'h00;
	logic [9:0] max_duty = 10'h258, max_accel = 10'h000;
	logic rx_pulse, cmd_busy, reply_valid, reply_two;
	logic [11:0] feedback_sense_pin_level, raw_feedback, scaled_feedback, target;
	logic [7:0] current_sense_level, current_reading;
	logic [15:0] raw_input, pid_count, reply_data, c;
	logic signed [15:0] error_sum, duty_target, duty_cycle;
	int n_errors = 0, checks = 0, cycles = 0;

	pmc_motor_ctrl #(.MS_CYCLES(10)) pmc_motor_ctrl_inst (.*);
	pmc_far_model pmc_far_model_inst (.*);

	always #10 clock = ~clock;

	task automatic finish_test();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			finish_test();
		end
	end

	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_val
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask : tick
	// Waits for the next n period updates, each bounded by a few periods
	task automatic wait_pid(input int n);
		repeat (n)
		begin
			c = pid_count;
			for (int i = 0; i < 25 && pid_count === c; i++)
				tick(1);
		end
	endtask : wait_pid
	task automatic set_target(input logic [11:0] v);
		set_target_valid = 1'b1;
		set_target_value = v;
		tick(1);
		set_target_valid = 1'b0;
		tick(1);
	endtask : set_target
	// Reply is due in the third cycle after the taking edge
	task automatic send_cmd(input logic [7:0] b);
		cmd_valid = 1'b1;
		cmd_byte = b;
		tick(1);
		cmd_valid = 1'b0;
		tick(2);
	endtask : send_cmd

	initial
	begin
		tick(6);
		rst = 1'b0;
		tick(12);
		for (int i = 0; i < 2; i++)
		begin
			set_target(i ? 12'h000 : 12'hfff);
			check_val({4'h0, target}, i ? 16'h0000 : 16'h0fff);
			check_val(raw_input, i ? 16'h0000 : 16'h0fff);
		end
		set_target(12'habc);
		tick(10);
		for (int b = 8'h80; b <= 8'hc0; b++)
		begin
			send_cmd(b[7:0]);
			check_val({15'h0, reply_valid}, {15'h0, b != 8'h80 && b != 8'hc0});
		end
		send_cmd(8'ha3);
		check_val({reply_two, reply_data[14:0]}, 16'h8abc);
		send_cmd(8'h84);
		check_val({reply_two, 7'h0, reply_data[7:0]}, 16'h000a);
		input_mode = 2'h1;
		rx_level = 12'hffc;
		in_offset = -16'sd100;
		tick(4);
		check_val(raw_input, 16'h0ffc);
		check_val({4'h0, target}, 16'h0f98);
		in_gain = 16'h0200;
		in_offset = 16'sh0000;
		tick(4);
		check_val({4'h0, target}, 16'h0fff);
		input_mode = 2'h2;
		for (int i = 0; i < 2; i++)
		begin
			pmc_far_model_inst.send_pulse(330 >> i);
			tick(3);
			check_val({15'h0, raw_input + 16'h1 >= (16'd10 >> i)
				&& raw_input <= (16'd10 >> i) + 16'h1}, 16'h0001);
		end
		input_mode = 2'h3;
		tick(2);
		check_val(raw_input, 16'h0000);
		input_mode = 2'h0;
		pmc_far_model_inst.set_levels(12'h7e4, 8'hff);
		tick(3);
		check_val({4'h0, raw_feedback}, 16'h0000);
		check_val({8'h0, current_reading}, 16'h0000);
		feedback_mode = 1'b1;
		current_limit_en = 1'b1;
		fb_offset = -16'sd10;
		tick(3);
		check_val({4'h0, raw_feedback}, 16'h07e4);
		check_val({4'h0, scaled_feedback}, 16'h07da);
		check_val({8'h0, current_reading}, 16'h00ff);
		feedback_mode = 1'b0;
		motor_enable = 1'b1;
		set_target(12'hbb8);
		wait_pid(3);
		check_val(duty_target, 16'h03b8);
		check_val(duty_cycle, 16'h0258);
		c = pid_count;
		wait_pid(1);
		check_val(pid_count, c + 16'h0001);
		set_target(12'h000);
		wait_pid(1);
		check_val(duty_target, 16'hf800);
		check_val(duty_cycle, 16'h0000);
		wait_pid(4);
		check_val(duty_cycle, 16'hfda8);
		max_duty = 10'h0c8;
		wait_pid(1);
		check_val(duty_cycle, 16'hff38);
		feedback_mode = 1'b1;
		max_duty = 10'h258;
		set_target(12'h7d0);
		motor_enable = 1'b0;
		wait_pid(1);
		check_val(error_sum, 16'h0000);
		motor_enable = 1'b1;
		wait_pid(1);
		check_val(error_sum, 16'h000a);
		wait_pid(10);
		check_val(error_sum, 16'h0064);
		check_val(duty_target, 16'h006e);
		reset_integral_opt = 1'b1;
		max_duty = 10'h005;
		wait_pid(1);
		check_val(error_sum, 16'h0000);
		// Acceleration limit both ways, overcurrent drives the goal to zero
		feedback_mode = 1'b0;
		reset_integral_opt = 1'b0;
		max_duty = 10'h258;
		motor_enable = 1'b0;
		set_target(12'hbb8);
		wait_pid(1);
		check_val(duty_cycle, 16'h0000);
		max_accel = 10'h064;
		motor_enable = 1'b1;
		wait_pid(1);
		check_val(duty_cycle, 16'h0064);
		wait_pid(1);
		check_val(duty_cycle, 16'h00c8);
		max_current = 8'h80;
		wait_pid(1);
		check_val(duty_cycle, 16'h0064);
		finish_test();
	end
endmodule : pmc_motor_ctrl_tb
